// ---- ddc_out_pkg.sv ----
// Purpose: constants and types for the output format and buffer block
// Assumes: one processing clock; register offsets are word indices
// Notes:   reserved bits are masked off on write and read back as zero
package ddc_out_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_PATH_CFG = 8'h14;
  localparam logic [7:0] ADDR_BUF_CTL = 8'h15;
  localparam logic [7:0] ADDR_PTR_RST = 8'h16;
  localparam logic [7:0] ADDR_ADVANCE = 8'h17;
  localparam logic [7:0] ADDR_SYNC_TRIG = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h19;
  localparam logic [31:0] PATH_CFG_MASK = 32'h03FF_FFFF;
  localparam logic [31:0] BUF_CTL_MASK = 32'h0000_FFFF;
  localparam logic [31:0] PATH_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] BUF_CTL_RST = 32'h0000_0000;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int LOWSRC_BIT = 25;
  localparam int IFMODE_BIT = 24;
  localparam int A_SEL_LSB = 22;
  localparam int B_SEL_LSB = 20;
  localparam int SYNC_POL_BIT = 19;
  localparam int CLK_POL_BIT = 18;
  localparam int SYNC_POS_BIT = 17;
  localparam int DIV_LSB = 14;
  localparam int TAG_I_LSB = 12;
  localparam int BUFMODE_BIT = 15;
  localparam int THR_LSB = 12;
  localparam int IVL_LSB = 4;
  localparam int CNT_LSB = 0;
  // ************************************************************
  // pointers, widths, counts
  // ************************************************************
  localparam logic [2:0] RD_PTR_RST = 3'h7;
  localparam logic [2:0] WR_PTR_RST = 3'h0;
  localparam logic [3:0] SER_LAST_BIT = 4'hF;
  localparam logic [4:0] SER_DIV_MAX = 5'h10;
  localparam logic [3:0] SNAP_MAX = 4'h8;

  typedef struct packed {
    logic [15:0] i_word;
    logic [15:0] q_word;
    logic [15:0] mag;
    logic [15:0] phase;
    logic [15:0] freq;
    logic [15:0] agc;
    logic [15:0] terr;
  } sample_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_s;

  typedef enum logic [1:0] {SER_IDLE, SER_PRE, SER_SHIFT, SER_POST}
    ser_state_e;
endpackage

// ---- output_format_and_buffer_ctrl.sv ----
// Purpose: output port formatting, serial framing and buffer RAM control
// Assumes: mclk is the processing clock; all inputs synchronous to it
// Notes:   input clock enters as a sampled level, not a clock domain
// Operation
// - low bytes from buffer or direct path
// - buffer read by 8-bit or 16-bit processor
// - port A carries I, magnitude or frequency
// - port B carries Q, phase or magnitude
// - sync polarity bit inverts serial sync
// - clock polarity picks data change edge
// - sync one bit after or before word
// - bit rate divides clock by 16..1
// - I tag passes, clears or sets LSB
// - six more words have own tags
// - buffer mode bit picks snapshot or FIFO
// - in FIFO mode, rising level hitting threshold raises interrupt, ready
// - snapshot interval is field plus one
// - each snapshot stores 0 to 8 samples
// - pointer reset: read 111, write 000
// - advance strobe steps to next set
// - sync strobe pulses one clock period
// - all control words act on mclk
module output_format_and_buffer_ctrl
  import ddc_out_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire bus_req_s bus,
  output logic [31:0] rdata,
  input wire logic sync_on_input_clock,
  input wire logic input_sample_clock,
  input wire sample_s sample,
  input wire logic sample_valid,
  input wire logic [2:0] up_addr,
  input wire logic up_ram_rd,
  input wire logic [2:0] word_sel,
  input wire logic port_b_read_enable_n,
  input wire logic [15:0] ser_word,
  input wire logic [2:0] ser_kind,
  input wire logic ser_load,
  output logic ser_busy,
  output logic ser_clk,
  output logic ser_data,
  output logic ser_sync,
  output logic [15:0] parallel_port_a,
  output logic [15:0] parallel_port_b,
  output logic fifo_int,
  output logic fifo_ready,
  output logic sync_pulse_pin
);
  // pointers are 3 bits wide, so only the eight-entry buffer is served
  if (DEPTH != 8) begin : g_bad_depth
    $error("DEPTH must be 8");
  end

  // ************************************************************
  // register bus
  // ************************************************************
  logic [31:0] path_cfg;
  logic [31:0] buf_ctl;
  wire wr_cfg = bus.wr && bus.addr == ADDR_PATH_CFG;
  wire wr_ctl = bus.wr && bus.addr == ADDR_BUF_CTL;
  wire ptr_rst = bus.wr && bus.addr == ADDR_PTR_RST;
  wire advance = bus.wr && bus.addr == ADDR_ADVANCE;
  wire sync_trig = bus.wr && bus.addr == ADDR_SYNC_TRIG;

  // config words land straight in mclk flops; reserved bits dropped
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      path_cfg <= PATH_CFG_RST;
      buf_ctl <= BUF_CTL_RST;
    end else begin
      if (wr_cfg) path_cfg <= bus.wdata & PATH_CFG_MASK;
      if (wr_ctl) buf_ctl <= bus.wdata & BUF_CTL_MASK;
    end
  end

  wire lowsrc = path_cfg[LOWSRC_BIT];
  wire ifmode = path_cfg[IFMODE_BIT];
  wire [1:0] a_sel = path_cfg[A_SEL_LSB +: 2];
  wire [1:0] b_sel = path_cfg[B_SEL_LSB +: 2];
  wire sync_pol = path_cfg[SYNC_POL_BIT];
  wire clk_pol = path_cfg[CLK_POL_BIT];
  wire sync_pos = path_cfg[SYNC_POS_BIT];
  wire [2:0] div_code = path_cfg[DIV_LSB +: 3];
  wire fifo_mode = buf_ctl[BUFMODE_BIT];
  wire [2:0] thr = buf_ctl[THR_LSB +: 3];
  wire [7:0] ivl = buf_ctl[IVL_LSB +: 8];
  wire [3:0] snap_n = buf_ctl[CNT_LSB +: 4];

  // ************************************************************
  // buffer RAM and pointers
  // ************************************************************
  logic [31:0] ram [DEPTH];
  logic [2:0] rd_ptr;
  logic [2:0] wr_ptr;
  logic [7:0] ivl_cnt;
  logic [3:0] snap_left;
  wire [2:0] level = wr_ptr - rd_ptr - 3'h1;
  wire full = wr_ptr == rd_ptr;
  wire empty = level == 3'h0;
  wire ivl_done = sample_valid && ivl_cnt == ivl;
  // fifo takes every sample while not full, snapshot only the granted ones
  wire snap_take = snap_left != 4'h0;
  wire take = sample_valid && !full && (fifo_mode || snap_take);
  wire step = advance && !empty;
  wire [2:0] next_level = level + 3'h1;
  wire hit = take && !step && fifo_mode && next_level == thr;
  // out-of-range counts are clamped so a snapshot never overruns
  wire [3:0] snap_grant = (snap_n > SNAP_MAX) ? SNAP_MAX : snap_n;

  // pointers; a reset write wins over a same-cycle advance or store
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ptr <= RD_PTR_RST;
      wr_ptr <= WR_PTR_RST;
    end else if (ptr_rst) begin
      rd_ptr <= RD_PTR_RST;
      wr_ptr <= WR_PTR_RST;
    end else begin
      if (step) rd_ptr <= rd_ptr + 3'h1;
      if (take) wr_ptr <= wr_ptr + 3'h1;
    end
  end

  // snapshot interval counter and sample grant
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ivl_cnt <= 8'h00;
      snap_left <= 4'h0;
    end else if (fifo_mode) begin
      ivl_cnt <= 8'h00;
      snap_left <= 4'h0;
    end else begin
      if (sample_valid) ivl_cnt <= ivl_done ? 8'h00 : ivl_cnt + 8'h01;
      if (ivl_done) snap_left <= snap_grant;
      else if (sample_valid && snap_take) snap_left <= snap_left - 4'h1;
    end
  end

  // interrupt pulse and ready flag; a hit beats a clearing event
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fifo_int <= 1'b0;
      fifo_ready <= 1'b0;
    end else begin
      fifo_int <= hit;
      if (hit) fifo_ready <= 1'b1;
      else if (ptr_rst || !fifo_mode || level < thr) fifo_ready <= 1'b0;
    end
  end

  // ************************************************************
  // processor read of the buffer
  // ************************************************************
  logic oe_q;
  logic [15:0] buf_word;
  wire [31:0] head = ram[rd_ptr];
  wire oe_rise = port_b_read_enable_n && !oe_q;
  // 8-bit side picks a byte lane, 16-bit side picks A or B word
  wire [1:0] lane = up_addr[1:0];
  wire [7:0] byte8 = head[8*lane +: 8];
  wire [15:0] word16 = word_sel[0] ? head[15:0] : head[31:16];
  wire rd_clk = ifmode ? oe_rise : up_ram_rd;
  wire [15:0] next_buf_word = ifmode ? word16 : {8'h00, byte8};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      oe_q <= 1'b1;
      buf_word <= 16'h0000;
    end else begin
      oe_q <= port_b_read_enable_n;
      if (rd_clk) buf_word <= next_buf_word;
    end
  end

  // ************************************************************
  // direct parallel ports
  // ************************************************************
  wire [15:0] direct_a = a_sel[1] ? sample.freq :
    (a_sel[0] ? sample.mag : sample.i_word);
  wire [15:0] direct_b = b_sel[1] ? sample.mag :
    (b_sel[0] ? sample.phase : sample.q_word);
  wire [7:0] low_a = lowsrc ? direct_a[7:0] : buf_word[7:0];
  wire [7:0] low_b = lowsrc ? direct_b[7:0] : buf_word[15:8];

  // ram entry holds port A word high, port B word low
  always_ff @(posedge mclk) begin
    if (take) ram[wr_ptr] <= {direct_a, direct_b};
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      parallel_port_a <= 16'h0000;
      parallel_port_b <= 16'h0000;
    end else begin
      parallel_port_a <= {direct_a[15:8], low_a};
      parallel_port_b <= {direct_b[15:8], low_b};
    end
  end

  // ************************************************************
  // serial framing
  // ************************************************************
  ser_state_e state;
  ser_state_e next_state;
  logic [4:0] div_cnt;
  logic [3:0] bit_cnt;
  logic [15:0] shreg;
  // 1XX runs at the full clock, else 16 >> code
  wire [4:0] period = div_code[2] ? 5'h01 : (SER_DIV_MAX >> div_code[1:0]);
  wire tick = div_cnt == period - 5'h01;
  wire [1:0] tag = path_cfg[TAG_I_LSB - 2 * ser_kind +: 2];
  wire tag_lsb = tag[1] ? 1'b1 : (tag[0] ? 1'b0 : ser_word[0]);
  wire start = ser_load && state == SER_IDLE;
  wire last = state == SER_SHIFT && bit_cnt == SER_LAST_BIT && tick;
  wire sync_on = state == SER_PRE || state == SER_POST;
  // clock half is high in first half of a bit, so at full rate it stays
  // low: the receiver must then use the processing clock itself
  wire half_hi = div_cnt < (period >> 1);

  always_comb begin
    next_state = state;
    case (state)
      SER_IDLE: if (start) next_state = sync_pos ? SER_PRE : SER_SHIFT;
      SER_PRE: if (tick) next_state = SER_SHIFT;
      SER_SHIFT: if (last) next_state = sync_pos ? SER_IDLE : SER_POST;
      SER_POST: if (tick) next_state = SER_IDLE;
      default: next_state = SER_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SER_IDLE;
      div_cnt <= 5'h00;
      bit_cnt <= 4'h0;
      shreg <= 16'h0000;
    end else begin
      state <= next_state;
      div_cnt <= (start || tick) ? 5'h00 : div_cnt + 5'h01;
      if (start) shreg <= {ser_word[15:1], tag_lsb};
      else if (state == SER_SHIFT && tick) shreg <= shreg << 1;
      if (start) bit_cnt <= 4'h0;
      else if (state == SER_SHIFT && tick) bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // serial pins registered; data moves at bit start
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ser_busy <= 1'b0;
      ser_clk <= 1'b0;
      ser_data <= 1'b0;
      ser_sync <= 1'b0;
    end else begin
      ser_busy <= next_state != SER_IDLE;
      ser_clk <= (state != SER_IDLE && half_hi) ^ clk_pol;
      ser_data <= state == SER_SHIFT && shreg[15];
      ser_sync <= sync_on ^ sync_pol;
    end
  end

  // ************************************************************
  // sync strobe pin
  // ************************************************************
  logic input_sample_clock_q;
  logic sync_wait;
  logic sync_hold;
  wire input_sample_clock_rise = input_sample_clock && !input_sample_clock_q;
  wire fast_pulse = sync_trig && !sync_on_input_clock;

  // slow mode waits for an input clock edge, then spans one period
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      input_sample_clock_q <= 1'b0;
      sync_wait <= 1'b0;
      sync_hold <= 1'b0;
      sync_pulse_pin <= 1'b0;
    end else begin
      input_sample_clock_q <= input_sample_clock;
      if (sync_trig && sync_on_input_clock) sync_wait <= 1'b1;
      else if (input_sample_clock_rise) sync_wait <= 1'b0;
      if (input_sample_clock_rise) sync_hold <= sync_wait;
      sync_pulse_pin <= fast_pulse || (sync_hold && !input_sample_clock_rise) ||
        (sync_wait && input_sample_clock_rise);
    end
  end

  // ************************************************************
  // register read, one cycle after the strobe
  // ************************************************************
  wire [31:0] status = {20'h00000, fifo_ready, empty, full, level,
    rd_ptr, wr_ptr};
  wire [31:0] next_rdata = bus.addr == ADDR_PATH_CFG ? path_cfg :
    bus.addr == ADDR_BUF_CTL ? buf_ctl :
    bus.addr == ADDR_STATUS ? status : 32'h0000_0000;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) rdata <= 32'h0000_0000;
    else rdata <= bus.rd ? next_rdata : 32'h0000_0000;
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_low_byte;
    !lowsrc ##1 !lowsrc |-> parallel_port_a[7:0] == $past(buf_word[7:0]);
  endproperty
  a_low_byte: assert property (p_low_byte)
    else $error("port A low byte not from buffer");

  property p_port_a;
    a_sel == 2'h1 |=> parallel_port_a[15:8] == $past(sample.mag[15:8]);
  endproperty
  a_port_a: assert property (p_port_a)
    else $error("port A high byte not magnitude");

  property p_port_b;
    b_sel[1] |=> parallel_port_b[15:8] == $past(sample.mag[15:8]);
  endproperty
  a_port_b: assert property (p_port_b)
    else $error("port B high byte not magnitude");

  property p_sync_pol;
    state == SER_IDLE && !sync_pol |=> !ser_sync;
  endproperty
  a_sync_pol: assert property (p_sync_pol)
    else $error("idle sync not low in normal polarity");

  property p_rate;
    state == SER_SHIFT && div_code == 3'h2 && tick |-> ##1 !tick [*3];
  endproperty
  a_rate: assert property (p_rate)
    else $error("bit tick spacing wrong for divide by 4");

  property p_tag_one;
    start && tag[1] |=> shreg[0];
  endproperty
  a_tag_one: assert property (p_tag_one)
    else $error("tag did not force LSB high");

  property p_ptr_rst;
    ptr_rst |=> rd_ptr == 3'h7 && wr_ptr == 3'h0 && empty;
  endproperty
  a_ptr_rst: assert property (p_ptr_rst)
    else $error("pointer reset values wrong");

  property p_advance;
    step && !ptr_rst |=> rd_ptr == $past(rd_ptr) + 3'h1;
  endproperty
  a_advance: assert property (p_advance)
    else $error("advance did not step read pointer");

  property p_sync_fast;
    fast_pulse |=> sync_pulse_pin ##1 !sync_pulse_pin;
  endproperty
  a_sync_fast: assert property (p_sync_fast)
    else $error("sync strobe not one cycle wide");

  property p_int;
    hit |=> fifo_int && fifo_ready;
  endproperty
  a_int: assert property (p_int)
    else $error("threshold hit gave no interrupt");

  c_fifo_hit: cover property (hit ##1 fifo_int);
  c_early_frame: cover property (start && sync_pos ##1 state == SER_PRE);
  c_snapshot: cover property (ivl_done && !fifo_mode ##1 snap_take);
  c_slow_sync: cover property (sync_wait ##[1:20] sync_pulse_pin);
endmodule

// ---- serial_sink_model.sv ----
// Purpose: serial receiver standing in for the DSP on the far side
// Assumes: divided bit rates only; the full-rate clock never toggles
// Notes:   bits are taken mid-bit, on the edge opposite the launch edge
module serial_sink_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_pol,
  input wire logic sync_pol,
  input wire logic ser_busy,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_sync,
  output logic [15:0] rx_word,
  output logic rx_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_q;
  logic [4:0] nbits;
  logic [15:0] shreg;
  logic mid_bit;
  logic sync_on;
  logic busy_q;

  // launch edge is rising for polarity 0, so falling is mid-bit
  assign mid_bit = (clk_q ^ clk_pol) && !(ser_clk ^ clk_pol);
  assign sync_on = ser_sync ^ sync_pol;
  assign rx_word = shreg;

  // shift msb first; sync bit times carry no data, so skip them
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clk_q <= 1'b0;
      nbits <= 5'h00;
      shreg <= 16'h0000;
      rx_valid <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      clk_q <= ser_clk;
      busy_q <= ser_busy;
      rx_valid <= 1'b0;
      // busy falls with the last bit in early mode: hold off one cycle
      if (!ser_busy && !busy_q) begin
        nbits <= 5'h00;
      end else if (mid_bit && !sync_on && nbits < 5'h10) begin
        shreg <= {shreg[14:0], ser_data};
        nbits <= nbits + 5'h01;
        rx_valid <= (nbits == 5'h0F);
      end
    end
  end
endmodule

// ---- output_format_and_buffer_ctrl_bench.sv ----
// Purpose: self-checking bench for the output format and buffer block
// Assumes: 10 MHz mclk; expectations queued, a monitor pops them
// Notes:   8-bit buffer read exercised; 16-bit read side held idle
module output_format_and_buffer_ctrl_bench;
  import ddc_out_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  bus_req_s bus = '0;
  logic [31:0] rdata;
  logic isc = 1'b0;
  sample_s sample = '0;
  logic sample_valid = 1'b0;
  logic [15:0] ser_word = 16'h0000;
  logic [2:0] ser_kind = 3'h0;
  logic ser_load = 1'b0;
  logic ser_busy, ser_clk, ser_data, ser_sync;
  logic [15:0] port_a, port_b, rx_word;
  logic fifo_int, fifo_ready, sync_pin, rx_valid, rd_q;
  logic cfg_pol = 1'b0;
  logic slow = 1'b0;
  logic ram_rd = 1'b0;
  logic [15:0] lfsr = 16'h0025;
  logic [31:0] cfg;
  logic [15:0] w, ea, eb;
  logic [1:0] tc;
  logic [31:0] q_exp[$];
  logic [31:0] q_mask[$];
  string q_what[$];
  int n_fail = 0;
  int n_compared = 0;
  int n_int = 0;
  int n_hi = 0;

  always #50 mclk = ~mclk;
  always #400 isc = ~isc; // 800 ns, eight mclk periods

  output_format_and_buffer_ctrl u_output_format_and_buffer_ctrl (
    .mclk(mclk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
    .sync_on_input_clock(slow), .input_sample_clock(isc),
    .sample(sample), .sample_valid(sample_valid),
    .up_addr(3'h0), .up_ram_rd(ram_rd), .word_sel(3'h0),
    .port_b_read_enable_n(1'b1), .ser_word(ser_word),
    .ser_kind(ser_kind), .ser_load(ser_load), .ser_busy(ser_busy),
    .ser_clk(ser_clk), .ser_data(ser_data), .ser_sync(ser_sync),
    .parallel_port_a(port_a), .parallel_port_b(port_b),
    .fifo_int(fifo_int), .fifo_ready(fifo_ready),
    .sync_pulse_pin(sync_pin));

  serial_sink_model u_serial_sink_model (
    .mclk(mclk), .rst_b(rst_b), .clk_pol(cfg_pol), .sync_pol(cfg_pol),
    .ser_busy(ser_busy), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_sync(ser_sync), .rx_word(rx_word), .rx_valid(rx_valid));

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] got);
    n_compared++;
    if (got !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, input string what);
    @(posedge mclk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    q_exp.push_back(e);
    q_mask.push_back(m);
    q_what.push_back(what);
    @(posedge mclk);
    bus.rd <= 1'b0;
  endtask

  task automatic push(input int n);
    repeat (n) begin
      @(posedge mclk);
      sample_valid <= 1'b1;
      @(posedge mclk);
      sample_valid <= 1'b0;
    end
  endtask

  // one edge first, so a busy flag launched by the last load is seen
  task automatic ser_idle();
    @(posedge mclk);
    for (int i = 0; i < 400 && ser_busy !== 1'b0; i++) begin
      @(posedge mclk);
    end
    if (ser_busy !== 1'b0) begin
      check("serial idle wait", 32'h0, 32'h1);
      report_and_stop();
    end
  endtask

  task automatic ser_send(input logic [2:0] k, input logic [15:0] d);
    ser_idle();
    ser_load <= 1'b1;
    ser_word <= d;
    ser_kind <= k;
    tc = cfg[13 - 2 * k -: 2];
    q_exp.push_back({16'h0000, d[15:1], tc[1] | (d[0] & ~tc[0])});
    q_mask.push_back(32'hFFFF_FFFF);
    q_what.push_back("serial word");
    @(posedge mclk);
    ser_load <= 1'b0;
  endtask

  task automatic do_reset();
    // let the last read answer retire before the flops are cleared
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
  endtask

  // monitor: each appearing result retires the oldest note
  always @(posedge mclk) rd_q <= bus.rd;
  always @(posedge mclk) n_int <= n_int + int'(fifo_int === 1'b1);
  always @(negedge mclk) begin
    if (rd_q || rx_valid === 1'b1) begin
      if (q_exp.size() == 0) begin
        check("unexpected result", 32'h0, 32'h1);
      end else if (rd_q) begin
        check(q_what.pop_front(), q_exp.pop_front(),
              rdata & q_mask.pop_front());
      end else begin
        check(q_what.pop_front(), q_exp.pop_front(), {16'h0000, rx_word});
        void'(q_mask.pop_front());
      end
    end
  end

  // watchdog so a stuck design cannot hang the run
  initial begin
    repeat (30000) @(posedge mclk);
    check("watchdog", 32'h0, 32'h1);
    report_and_stop();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    do_reset();
    rd(ADDR_PATH_CFG, PATH_CFG_RST, 32'hFFFF_FFFF, "cfg reset");
    rd(ADDR_BUF_CTL, BUF_CTL_RST, 32'hFFFF_FFFF, "ctl reset");
    rd(8'h20, 32'h0, 32'hFFFF_FFFF, "unmapped");
    wr(ADDR_PATH_CFG, 32'hFFFF_FFFF);
    rd(ADDR_PATH_CFG, PATH_CFG_MASK, 32'hFFFF_FFFF, "cfg");
    wr(ADDR_BUF_CTL, 32'hFFFF_FFFF);
    rd(ADDR_BUF_CTL, BUF_CTL_MASK, 32'hFFFF_FFFF, "ctl");
    wr(ADDR_STATUS, 32'hFFFF_FFFF);
    rd(ADDR_STATUS, 32'h438, 32'hFFF, "status");
    // direct parallel sources, every select code
    for (int s = 0; s < 4; s++) begin
      lfsr = lfsr_next(lfsr);
      w = lfsr;
      sample <= {w, ~w, {w[7:0], w[15:8]}, w ^ 16'h00FF,
                 w + 16'h1234, w ^ 16'h0F0F, w ^ 16'hFF00};
      wr(ADDR_PATH_CFG, {6'h00, 2'b10, s[1:0], s[1:0], 20'h0});
      ea = (s == 0) ? w : (s == 1) ? {w[7:0], w[15:8]} : w + 16'h1234;
      eb = (s == 0) ? ~w : (s == 1) ? w ^ 16'h00FF : {w[7:0], w[15:8]};
      repeat (3) @(posedge mclk);
      #1 check("port a", {16'h0, ea}, {16'h0, port_a});
      check("port b", {16'h0, eb}, {16'h0, port_b});
    end
    // sync strobe is exactly one mclk wide
    wr(ADDR_SYNC_TRIG, 32'h0);
    #1 check("sync pin high", 32'h1, {31'h0, sync_pin});
    @(posedge mclk);
    #1 check("sync pin low", 32'h0, {31'h0, sync_pin});
    // input clock timing: one input clock period, eight mclk periods
    slow <= 1'b1;
    wr(ADDR_SYNC_TRIG, 32'h0);
    repeat (40) begin
      @(posedge mclk);
      n_hi += int'(sync_pin === 1'b1);
    end
    check("slow sync width", 32'h8, n_hi);
    slow <= 1'b0;
    // fifo: threshold 2, then fill past full, then advance
    wr(ADDR_BUF_CTL, 32'h0000_A000);
    wr(ADDR_PTR_RST, 32'h0);
    rd(ADDR_STATUS, 32'h438, 32'hFFF, "ptr reset");
    push(2);
    repeat (4) @(posedge mclk);
    check("int count", 32'h1, n_int);
    #1 check("ready", 32'h1, {31'h0, fifo_ready});
    rd(ADDR_STATUS, 32'h880, 32'hFC0, "level 2");
    push(7);
    rd(ADDR_STATUS, 32'h3C0, 32'h3C0, "full");
    wr(ADDR_ADVANCE, 32'h0);
    rd(ADDR_STATUS, 32'h0, 32'h38, "rd wrap");
    wr(ADDR_PTR_RST, 32'h0);
    rd(ADDR_STATUS, 32'h438, 32'hFFF, "ptr reset 2");
    // snapshot: interval 3 samples, 2 stored per snapshot
    do_reset();
    wr(ADDR_BUF_CTL, 32'h0000_0022);
    push(3);
    rd(ADDR_STATUS, 32'h0, 32'h1C0, "snap wait");
    push(3);
    rd(ADDR_STATUS, 32'h80, 32'h1C0, "snap store");
    // 8-bit read of lane 0 (port B low byte) onto port A low byte
    wr(ADDR_ADVANCE, 32'h0);
    ram_rd <= 1'b1;
    @(posedge mclk);
    ram_rd <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 check("buf a", {16'h0, w[15:8], ~w[7:0]}, {16'h0, port_a});
    check("buf b", {16'h0, ~w[15:8], 8'h00}, {16'h0, port_b});
    // serial: /2 late sync normal, then /4 early sync inverted
    for (int p = 0; p < 2; p++) begin
      ser_idle();
      lfsr = lfsr_next(lfsr);
      cfg = {12'h0, {3{p[0]}}, 2'b01, ~p[0], lfsr[13:0]};
      wr(ADDR_PATH_CFG, cfg);
      cfg_pol <= p[0];
      for (int k = 0; k < 7; k++) begin
        lfsr = lfsr_next(lfsr);
        ser_send(k[2:0], lfsr);
      end
    end
    for (int i = 0; i < 400 && q_exp.size() != 0; i++) begin
      @(posedge mclk);
    end
    check("pending notes", 32'h0, q_exp.size());
    report_and_stop();
  end
endmodule
